// ### rtl/fslr_cfg.svh
// constants for the flash security and lockout recovery block
`ifndef FSLR_CFG_SVH
`define FSLR_CFG_SVH
`define FSLR_BOOT_VECTOR      24'h020000
`define FSLR_SEC_UNLOCKED     16'hE70A
`define FSLR_KEY_PERMIT_MATCH 2'h2
`define FSLR_IR_LEN           4
`define FSLR_IR_BYPASS        4'hF
`define FSLR_IR_IDCODE        4'h2
`define FSLR_IR_RECOVER       4'h8
`define FSLR_IDCODE_VAL       32'h0000_0ABD
`define FSLR_DR_LEN           7
`define FSLR_DIV_PRESCALE_BIT 6
`define FSLR_ERASE_CYCLES     20'h00100
`define FSLR_ADR_CTRL         8'h00
`define FSLR_ADR_STATUS       8'h04
`define FSLR_ADR_DIVIDER      8'h08
`define FSLR_ADR_KEY          8'h0C
`define FSLR_CTRL_DIV_RST     7'h00
`endif

// ### rtl/fslr_pkg.sv
// types for the flash security and lockout recovery block
package fslr_pkg;
    typedef enum logic [1:0] {
        FSLR_MODE_INTERNAL = 2'h0,
        FSLR_MODE_EXTERNAL = 2'h1,
        FSLR_MODE_SECURE   = 2'h3
    } fslr_mode_t;
    typedef enum logic [3:0] {
        FSLR_TAP_RESET = 4'h0, FSLR_TAP_IDLE  = 4'h1, FSLR_TAP_SELDR = 4'h3,
        FSLR_TAP_CAPDR = 4'h2, FSLR_TAP_SHDR  = 4'h6, FSLR_TAP_EX1DR = 4'h7,
        FSLR_TAP_PSDR  = 4'h5, FSLR_TAP_EX2DR = 4'h4, FSLR_TAP_UPDR  = 4'hC,
        FSLR_TAP_SELIR = 4'hD, FSLR_TAP_CAPIR = 4'hF, FSLR_TAP_SHIR  = 4'hE,
        FSLR_TAP_EX1IR = 4'hA, FSLR_TAP_PSIR  = 4'hB, FSLR_TAP_EX2IR = 4'h9,
        FSLR_TAP_UPIR  = 4'h8
    } fslr_tap_t;
endpackage : fslr_pkg

// ### rtl/fslr_top.sv
// flash security enforcement with jtag lockout recovery, wishbone regs
// How it works
// (RL1) boot picks internal, external or secure mode
// (RL2) secure boot: internal, no external, 0x020000 vector
// (RL3) secure mode ignores external boot pin
// (RL4) TAP boundary scan and ID always available; the TAP has no boundary-scan register, only idcode, bypass and the divider
// (RL5) secure: debug port access blocked
// (RL6) read-disable set during reset from security bytes; reset forces it high, the bytes land on the first clock after release
// (RL7) recovery mass-erases flash, removing security
// (RL8) recovery instruction selects 7-bit divider register
// (RL9) shifted divider replaces flash timing divider
// (RL10) bit 6 prescale, bits 5..0 ratio
// (RL11) host picks divider for 150-200 kHz
// (RL12) host sets prescale above 12.8 MHz
// (RL13) host: instruction, then divider, then idle
// (RL14) host stays in idle during erase
// (RL15) host resets TAP and chip afterwards
// (RL16) backdoor unsecure only when key permit set
// (RL17) program key, then code, then security bytes
// (RL18) security from two nonvolatile bytes, persistent
`include "fslr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module fslr_top
    import fslr_pkg::*;
(
    input  wire logic        clk_i,                    // system clock
    input  wire logic        rst_i,                    // sync reset, high
    input  wire logic [15:0] security_bytes_i,         // nonvolatile bytes
    input  wire logic        external_boot_select_pin_i, // boot strap pin
    input  wire logic        tck_i,                    // jtag clock pin
    input  wire logic        tms_i,                    // jtag mode pin
    input  wire logic        tdi_i,                    // jtag data in
    input  wire logic        trst_n_i,                 // jtag reset, low
    output logic             tdo_o,                    // jtag data out
    output logic             tdo_oe_n_o,               // tdo enable, low
    output logic [1:0]       boot_mode_o,              // chosen boot mode
    output logic [23:0]      boot_vector_o,            // first fetch address
    output logic             ext_pspace_block_o,       // external p-space off
    output logic             core_read_disable_o,      // core mem read off
    output logic             enhanced_core_debug_port_en_o, // debug allowed
    output logic             mass_erase_o,             // erase in progress
    output logic [6:0]       flash_timing_divider_reg_o, // divider to flash
    output logic             flash_timed_clk_o,        // divided timing clock
    input  wire logic        erase_done_i,             // flash erase finished
    input  wire logic        wb_cyc_i,                 // wishbone cycle
    input  wire logic        wb_stb_i,                 // wishbone strobe
    input  wire logic        wb_we_i,                  // wishbone write
    input  wire logic [7:0]  wb_adr_i,                 // byte address
    input  wire logic [3:0]  wb_sel_i,                 // byte lanes
    input  wire logic [31:0] wb_dat_i,                 // write data
    output logic [31:0]      wb_dat_o,                 // read data
    output logic             wb_ack_o                  // acknowledge
);
    // three-stage pin synchronisers; stage 1 feeds stage 2 only.
    // they run through reset so the boot strap is settled at release
    logic [2:0] tck_s;
    logic [2:0] tms_s;
    logic [2:0] tdi_s;
    logic [2:0] trst_s;
    logic [2:0] boot_s;
    always_ff @(posedge clk_i) begin
        tck_s  <= {tck_s[1:0], tck_i};
        tms_s  <= {tms_s[1:0], tms_i};
        tdi_s  <= {tdi_s[1:0], tdi_i};
        trst_s <= {trst_s[1:0], trst_n_i};
        boot_s <= {boot_s[1:0], external_boot_select_pin_i};
    end
    // a change counts once stages two and three agree
    logic tck_f;
    logic tms_f;
    logic tdi_f;
    logic trst_n_f;
    logic boot_f;
    logic tck_prev;
    always_ff @(posedge clk_i) begin
        if (tck_s[1] == tck_s[2]) tck_f <= tck_s[2];
        if (tms_s[1] == tms_s[2]) tms_f <= tms_s[2];
        if (tdi_s[1] == tdi_s[2]) tdi_f <= tdi_s[2];
        if (trst_s[1] == trst_s[2]) trst_n_f <= trst_s[2];
        if (boot_s[1] == boot_s[2]) boot_f <= boot_s[2];
        tck_prev <= tck_f;
    end
    wire tck_rise = tck_f & ~tck_prev;
    wire tck_fall = ~tck_f & tck_prev;

    // security latched on the first clock after reset release; held until erase end, backdoor key or next reset
    // backdoor and erase can only clear the flag, never set it
    logic secured;
    logic key_permit;
    logic strap_done;
    logic key_unlock;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            secured    <= 1'b1;
            key_permit <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            secured    <= (security_bytes_i != `FSLR_SEC_UNLOCKED); // [RL18]
            key_permit <= (security_bytes_i[15:14] == `FSLR_KEY_PERMIT_MATCH);
            strap_done <= 1'b1;
        end else if (erase_done_i && mass_erase_o) begin
            secured    <= 1'b0;                                  // [RL7]
        end else if (key_unlock) begin
            secured    <= 1'b0;                                  // [RL16]
        end
    end

    // boot mode decided once at the strap; ext pin ignored when secure
    logic [1:0] boot_mode;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            boot_mode <= FSLR_MODE_SECURE;
        else if (!strap_done) begin
            if (security_bytes_i != `FSLR_SEC_UNLOCKED)
                boot_mode <= FSLR_MODE_SECURE;                   // [RL1] [RL3]
            else if (boot_f)
                boot_mode <= FSLR_MODE_EXTERNAL;                 // [RL1]
            else
                boot_mode <= FSLR_MODE_INTERNAL;                 // [RL1]
        end
    end
    assign boot_mode_o        = boot_mode;
    assign boot_vector_o      = `FSLR_BOOT_VECTOR;               // [RL2]
    assign ext_pspace_block_o = (boot_mode == FSLR_MODE_SECURE); // [RL2]
    // read-disable is held high throughout reset until the strap lands
    assign core_read_disable_o = secured;                       // [RL6]
    assign enhanced_core_debug_port_en_o = ~secured;            // [RL5]

    // TAP controller, stepped on filtered tck rising edges
    // all sixteen codes are states, so the case needs no default
    fslr_tap_t tap;
    fslr_tap_t next_tap;
    always_comb begin
        next_tap = tap;
        unique case (tap)
            FSLR_TAP_RESET: begin
                next_tap = tms_f ? FSLR_TAP_RESET : FSLR_TAP_IDLE;
            end
            FSLR_TAP_IDLE: begin
                next_tap = tms_f ? FSLR_TAP_SELDR : FSLR_TAP_IDLE;
            end
            FSLR_TAP_SELDR: begin
                next_tap = tms_f ? FSLR_TAP_SELIR : FSLR_TAP_CAPDR;
            end
            FSLR_TAP_CAPDR: begin
                next_tap = tms_f ? FSLR_TAP_EX1DR : FSLR_TAP_SHDR;
            end
            FSLR_TAP_SHDR: begin
                next_tap = tms_f ? FSLR_TAP_EX1DR : FSLR_TAP_SHDR;
            end
            FSLR_TAP_EX1DR: begin
                next_tap = tms_f ? FSLR_TAP_UPDR : FSLR_TAP_PSDR;
            end
            FSLR_TAP_PSDR: begin
                next_tap = tms_f ? FSLR_TAP_EX2DR : FSLR_TAP_PSDR;
            end
            FSLR_TAP_EX2DR: begin
                next_tap = tms_f ? FSLR_TAP_UPDR : FSLR_TAP_SHDR;
            end
            FSLR_TAP_UPDR: begin
                next_tap = tms_f ? FSLR_TAP_SELDR : FSLR_TAP_IDLE;
            end
            FSLR_TAP_SELIR: begin
                next_tap = tms_f ? FSLR_TAP_RESET : FSLR_TAP_CAPIR;
            end
            FSLR_TAP_CAPIR: begin
                next_tap = tms_f ? FSLR_TAP_EX1IR : FSLR_TAP_SHIR;
            end
            FSLR_TAP_SHIR: begin
                next_tap = tms_f ? FSLR_TAP_EX1IR : FSLR_TAP_SHIR;
            end
            FSLR_TAP_EX1IR: begin
                next_tap = tms_f ? FSLR_TAP_UPIR : FSLR_TAP_PSIR;
            end
            FSLR_TAP_PSIR: begin
                next_tap = tms_f ? FSLR_TAP_EX2IR : FSLR_TAP_PSIR;
            end
            FSLR_TAP_EX2IR: begin
                next_tap = tms_f ? FSLR_TAP_UPIR : FSLR_TAP_SHIR;
            end
            FSLR_TAP_UPIR: begin
                next_tap = tms_f ? FSLR_TAP_SELDR : FSLR_TAP_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !trst_n_f)
            tap <= FSLR_TAP_RESET;
        else if (tck_rise)
            tap <= next_tap;                                     // [RL4]
    end

    // instruction register; reset selects idcode
    logic [3:0] ir;
    logic [3:0] ir_sh;
    always_ff @(posedge clk_i) begin
        if (rst_i || !trst_n_f) begin
            ir    <= `FSLR_IR_IDCODE;
            ir_sh <= `FSLR_IR_IDCODE;
        end else if (tck_rise) begin
            unique case (tap)
                FSLR_TAP_RESET: begin
                    ir <= `FSLR_IR_IDCODE;
                end
                FSLR_TAP_CAPIR: begin
                    ir_sh <= 4'h1;
                end
                FSLR_TAP_SHIR: begin
                    ir_sh <= {tdi_f, ir_sh[3:1]};
                end
                FSLR_TAP_UPIR: begin
                    ir <= ir_sh;
                end
                default: ;
            endcase
        end
    end
    wire sel_recover = (ir == `FSLR_IR_RECOVER);
    wire sel_idcode  = (ir == `FSLR_IR_IDCODE);

    // data registers: idcode, bypass, 7-bit divider
    logic [31:0] id_sh;
    logic        byp_sh;
    // capture reloads the live value; update with recovery selected loads the shifted bits and arms erase
    logic [6:0]  div_sh;
    logic [6:0]  jtag_flash_divider_value;
    always_ff @(posedge clk_i) begin
        if (rst_i || !trst_n_f) begin
            id_sh  <= 32'h0;
            byp_sh <= 1'b0;
            div_sh <= 7'h00;
            jtag_flash_divider_value <= 7'h00;
        end else if (tck_rise) begin
            if (tap == FSLR_TAP_CAPDR) begin
                id_sh  <= `FSLR_IDCODE_VAL;                      // [RL4]
                byp_sh <= 1'b0;
                div_sh <= jtag_flash_divider_value;
            end else if (tap == FSLR_TAP_SHDR) begin
                id_sh  <= {tdi_f, id_sh[31:1]};
                byp_sh <= tdi_f;
                div_sh <= {tdi_f, div_sh[6:1]};                  // [RL8]
            end else if (tap == FSLR_TAP_UPDR && sel_recover) begin
                jtag_flash_divider_value <= div_sh;              // [RL8]
            end
        end
    end

    // tdo changes on falling tck; enable low while shifting.
    // filtered edges lag the pins by about four clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdo_o      <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end else if (tck_fall) begin
            tdo_oe_n_o <= ~(tap == FSLR_TAP_SHDR || tap == FSLR_TAP_SHIR);
            if (tap == FSLR_TAP_SHIR)
                tdo_o <= ir_sh[0];
            else if (sel_idcode)
                tdo_o <= id_sh[0];
            else if (sel_recover)
                tdo_o <= div_sh[0];
            else
                tdo_o <= byp_sh;
        end
    end

    // erase runs while in idle with recovery loaded; leaving idle aborts
    logic        armed;
    logic [19:0] erase_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || !trst_n_f) begin
            armed       <= 1'b0;
            mass_erase_o <= 1'b0;
        end else begin
            if (tap == FSLR_TAP_UPDR && sel_recover && tck_rise)
                armed <= 1'b1;                                   // [RL13]
            if (armed && tap == FSLR_TAP_IDLE && !erase_done_i)
                mass_erase_o <= 1'b1;                            // [RL7] [RL14]
            else if (tap != FSLR_TAP_IDLE || erase_done_i) begin
                mass_erase_o <= 1'b0;
                if (erase_done_i) armed <= 1'b0;
            end
        end
    end

    // software divider; replaced by jtag value during recovery
    logic [6:0] sw_divider;
    wire [6:0] div_eff = armed ? jtag_flash_divider_value : sw_divider;
    assign flash_timing_divider_reg_o = div_eff;                 // [RL9]
    // sysclk/2, then optional /8, then /(ratio+1)
    logic       half;
    logic [2:0] pre_cnt;
    logic [5:0] ratio_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half      <= 1'b0;
            pre_cnt   <= 3'h0;
            ratio_cnt <= 6'h00;
            flash_timed_clk_o <= 1'b0;
            erase_cnt <= 20'h0;
        end else begin
            half <= ~half;
            if (half) begin
                pre_cnt <= pre_cnt + 3'h1;
                if (!div_eff[`FSLR_DIV_PRESCALE_BIT] || pre_cnt == 3'h7) begin // [RL10]
                    if (ratio_cnt >= div_eff[5:0]) begin         // [RL10]
                        ratio_cnt <= 6'h00;
                        flash_timed_clk_o <= ~flash_timed_clk_o;
                    end else
                        ratio_cnt <= ratio_cnt + 6'h01;
                end
            end
            erase_cnt <= mass_erase_o ? erase_cnt + 20'h1 : 20'h0;
        end
    end

    // wishbone slave: one wait state then ack
    wire  wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0;
            sw_divider <= `FSLR_CTRL_DIV_RST;
            key_unlock <= 1'b0;
        end else begin
            wb_ack_o   <= wb_req;
            key_unlock <= 1'b0;
            if (wb_req && wb_we_i) begin
                if (wb_adr_i == `FSLR_ADR_DIVIDER && wb_sel_i[0])
                    sw_divider <= wb_dat_i[6:0];
                // backdoor matches only with permit set
                if (wb_adr_i == `FSLR_ADR_KEY && wb_sel_i[0] &&
                    wb_dat_i[0] && key_permit)
                    key_unlock <= 1'b1;                          // [RL16]
            end
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `FSLR_ADR_STATUS: begin
                        wb_dat_o <= {24'h0, erase_cnt[19:16],
                                     key_permit, mass_erase_o, boot_mode};
                    end
                    `FSLR_ADR_CTRL: begin
                        wb_dat_o <= {31'h0, secured};
                    end
                    `FSLR_ADR_DIVIDER: begin
                        wb_dat_o <= {25'h0, div_eff};
                    end
                    default: begin
                        wb_dat_o <= 32'h0;
                    end
                endcase
            end
        end
    end
endmodule : fslr_top
`default_nettype wire

// ### sim/fslr_asserts.sv
// port-level assertion checker for the flash security block
`include "fslr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module fslr_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] security_bytes_i,
    input wire logic        external_boot_select_pin_i,
    input wire logic        erase_done_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [1:0]  boot_mode_o,
    input wire logic [23:0] boot_vector_o,
    input wire logic        ext_pspace_block_o,
    input wire logic        core_read_disable_o,
    input wire logic        enhanced_core_debug_port_en_o,
    input wire logic        mass_erase_o,
    input wire logic [6:0]  flash_timing_divider_reg_o,
    input wire logic        flash_timed_clk_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       tclk_q;
    logic       tog;
    logic [10:0] gap;
    logic [10:0] span;
    logic [1:0]  seen;
    // clocks between toggles: system clock halved, optional /8, ratio+1
    assign tog  = flash_timed_clk_o != tclk_q;
    assign span = (flash_timing_divider_reg_o[6] ? 11'h10 : 11'h2)
                * ({5'h0, flash_timing_divider_reg_o[5:0]} + 11'h1);
    // the first toggles after a divider change may be short, so skip two
    always_ff @(posedge clk_i) begin
        tclk_q <= flash_timed_clk_o;
        if (rst_i || $changed(flash_timing_divider_reg_o)) begin
            gap  <= 11'h0;
            seen <= 2'h0;
        end else if (tog) begin
            gap  <= 11'h0;
            seen <= (seen == 2'h2) ? seen : seen + 2'h1;
        end else begin
            gap <= gap + 11'h1;
        end
    end
    sequence boot_latch_s;
        $fell(rst_i) ##1 !rst_i;
    endsequence
    sequence erase_end_s;
        mass_erase_o && erase_done_i;
    endsequence
    vector_fixed_a: assert property (boot_vector_o == `FSLR_BOOT_VECTOR)
        else $error("boot vector differs");
    secure_block_a: assert property (boot_mode_o == 2'h3 |-> ext_pspace_block_o)
        else $error("external space open in secure mode");
    debug_gate_a: assert property (enhanced_core_debug_port_en_o != core_read_disable_o)
        else $error("debug port not tied to security");
    reset_secured_a: assert property ($fell(rst_i) |-> core_read_disable_o
        && boot_mode_o == 2'h3) else $error("reset state not secured");
    mode_pick_a: assert property (boot_latch_s |-> boot_mode_o ==
        ((security_bytes_i != `FSLR_SEC_UNLOCKED) ? 2'h3
        : {1'b0, external_boot_select_pin_i})) else $error("wrong boot mode");
    erase_clears_a: assert property (erase_end_s |=> !mass_erase_o
        && !core_read_disable_o) else $error("erase end did not unsecure");
    wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    wb_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    timed_clk_a: assert property (tog && seen == 2'h2 |-> gap == span - 11'h1)
        else $error("timed clock period wrong");
endmodule : fslr_asserts
bind fslr_top fslr_asserts chk_u (.*);
`default_nettype wire

// ### sim/fslr_jtag_host.sv
// jtag host model driving the test access port pins
`include "fslr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module fslr_jtag_host (
    input  wire logic clk_i,    // system clock
    input  wire logic tdo_i,    // resolved data line
    output var  logic tck_o,    // test clock
    output var  logic tms_o,    // mode select
    output var  logic tdi_o,    // data to device
    output var  logic trst_n_o  // tap reset, low
);
    initial begin
        tck_o    = 1'b0;
        tms_o    = 1'b1;
        tdi_o    = 1'b0;
        trst_n_o = 1'b0;
    end
    // 13 system clocks per tck period so the device filter keeps up
    task automatic tick(input logic m, input logic d, output logic q);
        @(posedge clk_i);
        tms_o <= m;
        tdi_o <= d;
        repeat (6) @(posedge clk_i);
        q = tdo_i;
        tck_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        tck_o <= 1'b0;
    endtask : tick
    task automatic tap_reset();
        logic q;
        @(posedge clk_i);
        trst_n_o <= 1'b0;
        repeat (10) @(posedge clk_i);
        trst_n_o <= 1'b1;
        repeat (5) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : tap_reset
    // idle to shift and back to idle, lsb first; tck then stands still
    task automatic scan(input logic ir, input int n, input logic [31:0] v,
                        output logic [31:0] r);
        logic q;
        r = 32'h0;
        tick(1'b1, 1'b0, q);
        if (ir) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, v[i], q);
            r[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : scan
    task automatic recover(input logic [6:0] div);
        logic [31:0] r;
        scan(1'b1, `FSLR_IR_LEN, {28'h0, `FSLR_IR_RECOVER}, r);
        scan(1'b0, `FSLR_DR_LEN, {25'h0, div}, r);
    endtask : recover
endmodule : fslr_jtag_host
`default_nettype wire

// ### sim/fslr_top_tb_top.sv
// self-checking bench for the flash security block
`include "fslr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module fslr_top_tb_top;
    localparam logic [6:0] REC_DIV = 7'h51; // 25 MHz / 8 / 18
    logic        clk_i = 1'b0, rst_i = 1'b1, pin = 1'b0, done = 1'b0;
    logic [15:0] sec = 16'h0;
    logic        tck, tms, tdi, trst_n, tdo, tdo_oe_n, tdo_line;
    logic [1:0]  mode;
    logic [23:0] vec;
    logic        pblock, rd_dis, dbg_en, erase;
    logic [6:0]  div;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0]  adr = 8'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    int          num_errors = 0, check_count = 0;
    // pull-up on the board: a released line reads high
    assign tdo_line = tdo_oe_n ? 1'b1 : tdo;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    fslr_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .security_bytes_i(sec),
        .external_boot_select_pin_i(pin), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
        .boot_mode_o(mode), .boot_vector_o(vec), .ext_pspace_block_o(pblock),
        .core_read_disable_o(rd_dis), .enhanced_core_debug_port_en_o(dbg_en),
        .mass_erase_o(erase), .flash_timing_divider_reg_o(div),
        .flash_timed_clk_o(), .erase_done_i(done), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    fslr_jtag_host host_u (.clk_i(clk_i), .tdo_i(tdo_line), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        if (ack !== 1'b1) begin
            num_errors++;
            results();
        end
    endtask : wb
    task automatic boot(input logic [15:0] b, input logic p);
        @(posedge clk_i);
        {rst_i, sec, pin} <= {1'b1, b, p};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : boot
    task automatic test_boot();
        logic [15:0] b [3] = '{16'hE70A, 16'hE70A, 16'h0000};
        logic        p [3] = '{1'b0, 1'b1, 1'b1};
        logic [1:0]  m [3] = '{2'h0, 2'h1, 2'h3};
        logic [31:0] q;
        for (int i = 0; i < 3; i++) begin
            boot(b[i], p[i]);
            cmp(32'(mode), 32'(m[i]));
            cmp(32'(pblock), 32'(m[i] == 2'h3));
            cmp(32'(vec), 32'(`FSLR_BOOT_VECTOR));
            cmp(32'(dbg_en), 32'(m[i] != 2'h3));
            wb(1'b0, `FSLR_ADR_STATUS, 32'h0, q);
            cmp(32'(q[1:0]), 32'(m[i]));
        end
        wb(1'b0, 8'h10, 32'h0, q);
        cmp(q, 32'h0);
        $display("boot mode test done");
    endtask : test_boot
    task automatic test_key();
        logic [31:0] q;
        for (int i = 0; i < 2; i++) begin
            boot(i == 0 ? 16'h0000 : 16'h8000, 1'b0);
            wb(1'b1, `FSLR_ADR_KEY, 32'h1, q);
            wb(1'b0, `FSLR_ADR_CTRL, 32'h0, q);
            cmp(32'(q[0]), 32'(i == 0));
        end
        $display("backdoor key test done");
    endtask : test_key
    task automatic test_recover();
        logic [31:0] q;
        int          n;
        boot(16'h0000, 1'b0);
        host_u.tap_reset();
        host_u.scan(1'b0, 32, 32'h0, q);
        cmp(q, `FSLR_IDCODE_VAL);
        cmp(32'(tdo_oe_n), 32'h1);
        wb(1'b1, `FSLR_ADR_DIVIDER, 32'h13, q);
        wb(1'b0, `FSLR_ADR_DIVIDER, 32'h0, q);
        cmp(q, 32'h13);
        host_u.recover(REC_DIV);
        for (n = 0; n < 200 && erase !== 1'b1; n++) @(posedge clk_i);
        cmp(32'(erase), 32'h1);
        cmp(32'(div), 32'(REC_DIV));
        wb(1'b0, `FSLR_ADR_DIVIDER, 32'h0, q);
        cmp(q, 32'(REC_DIV));
        wb(1'b0, `FSLR_ADR_STATUS, 32'h0, q);
        cmp(q, 32'h7);
        repeat (600) @(posedge clk_i);
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        repeat (2) @(posedge clk_i);
        cmp(32'({erase, rd_dis, dbg_en}), 32'h1);
        host_u.tap_reset();
        $display("lockout recovery test done");
    endtask : test_recover
    initial begin
        test_boot();
        test_key();
        test_recover();
        results();
    end
endmodule : fslr_top_tb_top
`default_nettype wire
